// [logic/tcp_params.svh]
// offsets, field positions, reset values and pin indices of the timer/counter/pwm unit
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define TCP_ADDR_W 8
`define TCP_OFF_CTRL 8'h00
`define TCP_OFF_PERIOD 8'h04
`define TCP_OFF_COMPARE 8'h08
`define TCP_OFF_DEADBAND 8'h0c
`define TCP_OFF_COUNT 8'h10
`define TCP_OFF_CAPTURE 8'h14
`define TCP_OFF_STATUS 8'h18
`define TCP_OFF_DIV 8'h1c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TCP_CTRL_W 13
`define TCP_CTRL_RUN 0
`define TCP_CTRL_MODE 1
`define TCP_CTRL_REL 3
`define TCP_CTRL_CSEL 6
`define TCP_CTRL_COMP 8
`define TCP_CTRL_START 9
`define TCP_CTRL_IMASK 10

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define TCP_ST_TC 0
`define TCP_ST_CMP 1
`define TCP_ST_CAP 2
`define TCP_ST_RUN 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TCP_CTRL_RST 13'h0000
`define TCP_PERIOD_RST 16'hffff
`define TCP_COMPARE_RST 16'h8000
`define TCP_DEADBAND_RST 8'h00
`define TCP_DIV_RST 16'h0000

// ----------------------------------------------------------------
// synchronised pin indices
// ----------------------------------------------------------------
`define TCP_PIN_XCLK 0
`define TCP_PIN_RST 1
`define TCP_PIN_CAP 2
`define TCP_PIN_KILL 3
`define TCP_PIN_EN 4
`define TCP_PIN_N 5

`endif

// [logic/tcp_pkg.sv]
// types of the timer/counter/pwm unit
package tcp_pkg;

    typedef enum logic [1:0] {
        TCP_MODE_FREE,
        TCP_MODE_ONESHOT,
        TCP_MODE_ENABLE,
        TCP_MODE_RSVD
    } tcp_mode_t;

    typedef enum logic [2:0] {
        TCP_REL_LT,
        TCP_REL_LTE,
        TCP_REL_EQ,
        TCP_REL_GTE,
        TCP_REL_GT,
        TCP_REL_RSVD5,
        TCP_REL_RSVD6,
        TCP_REL_RSVD7
    } tcp_rel_t;

    typedef enum logic [1:0] {
        TCP_CLK_SYS,
        TCP_CLK_DIV,
        TCP_CLK_PIN_RISE,
        TCP_CLK_PIN_FALL
    } tcp_csel_t;

    typedef struct packed {
        logic [12:0] ctrl;
        logic [15:0] period;
        logic [15:0] compare;
        logic [7:0] deadband;
        logic [15:0] div;
        logic [15:0] divcnt;
        logic [15:0] count;
        logic [15:0] capture;
        logic [2:0] sticky;
        logic running;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] sync3;
        logic [4:0] filt;
        logic [4:0] filt_prev;
        logic pwm;
        logic tc;
        logic irq;
        logic [31:0] rdata;
    } tcp_state_t;

    typedef struct packed {
        logic prev;
        logic [7:0] cnt;
        logic out_t;
        logic out_c;
    } tcp_db_state_t;

endpackage

// [logic/tcp_db_if.sv]
// carrier between the counter core and the dead-band output stage
`timescale 1ns/1ps
interface tcp_db_if;
    logic raw;
    logic tick;
    logic comp_en;
    logic kill;
    logic [7:0] band;
    logic out_t;
    logic out_c;

    modport ctl (output raw, output tick, output comp_en, output kill, output band,
                 input out_t, input out_c);
    modport db (input raw, input tick, input comp_en, input kill, input band,
                output out_t, output out_c);
endinterface

// [logic/tcp_deadband.sv]
// dead-band generator for the true and complementary pwm outputs
`timescale 1ns/1ps
module tcp_deadband
    import tcp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    tcp_db_if.db bus
);

    tcp_db_state_t q_ff;
    tcp_db_state_t nxt_q;
    logic settle;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        settle = 1'b0;
        if (bus.raw != q_ff.prev) begin
            // both outputs drop on every edge of the raw compare unless the band is zero
            nxt_q.prev = bus.raw;
            nxt_q.cnt = bus.band;
        end else if (q_ff.cnt != 8'h00 && bus.tick) begin
            nxt_q.cnt = q_ff.cnt - 8'h01;
        end
        settle = (nxt_q.cnt == 8'h00);
        // kill wins over everything, even inside the gap
        nxt_q.out_t = settle & nxt_q.prev & ~bus.kill;
        nxt_q.out_c = settle & ~nxt_q.prev & bus.comp_en & ~bus.kill;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign bus.out_t = q_ff.out_t;
    assign bus.out_c = q_ff.out_c;

endmodule

// [logic/tcp_timer.sv]
// 16-bit down-counting timer, counter and pwm unit with register port
//
// Overview of operation
// - counter is 16 bits and only counts down on enabled clocks
// - compare relation selectable: less, less-equal, equal, greater-equal, greater
// - period loads on start, on the reset input and at terminal count outside one shot
// - interrupt request on any masked mix of terminal count, compare, capture
// - drives compare, terminal count, interrupt; complementary compare optional
// - runs free, one shot, or counting under the enable input
// - one shot stops at the end of one period, no automatic restart
// - enable-controlled mode advances only while enable input is high
// - kill input forces both compare outputs off
// - capture input latches the full 16-bit count for firmware
// - true and complementary pwm separated by a gap with both off
// - counter clock chosen from several sources by configuration
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tcp_params.svh"
module tcp_timer
    import tcp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_ext_clk,
    input wire logic i_tmr_rst,
    input wire logic i_capture,
    input wire logic i_kill,
    input wire logic i_enable,
    output logic o_cmp,
    output logic o_cmp_n,
    output logic o_tc,
    output logic o_irq
);

    tcp_state_t q_ff;
    tcp_state_t nxt_q;
    tcp_db_if dbi ();

    logic [4:0] pins;
    logic [4:0] rise;
    logic [4:0] fall;
    logic div_tick;
    logic src_tick;
    logic advance;
    logic cmp_true;
    logic start;
    logic [2:0] set_ev;
    logic [2:0] clr_ev;
    tcp_mode_t mode;
    tcp_rel_t rel;
    tcp_csel_t csel;

    assign pins = {i_enable, i_kill, i_capture, i_tmr_rst, i_ext_clk};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.tc = 1'b0;
        set_ev = 3'h0;
        clr_ev = 3'h0;
        mode = tcp_mode_t'(q_ff.ctrl[`TCP_CTRL_MODE +: 2]);
        rel = tcp_rel_t'(q_ff.ctrl[`TCP_CTRL_REL +: 3]);
        csel = tcp_csel_t'(q_ff.ctrl[`TCP_CTRL_CSEL +: 2]);

        // pin synchroniser: a level counts once stages two and three agree
        nxt_q.sync1 = pins;
        nxt_q.sync2 = q_ff.sync1;
        nxt_q.sync3 = q_ff.sync2;
        for (int k = 0; k < `TCP_PIN_N; k++) begin
            if (q_ff.sync2[k] == q_ff.sync3[k]) begin
                nxt_q.filt[k] = q_ff.sync3[k];
            end
        end
        nxt_q.filt_prev = q_ff.filt;
        rise = q_ff.filt & ~q_ff.filt_prev;
        fall = ~q_ff.filt & q_ff.filt_prev;

        // ----------------------------------------------------------------
        // clock source
        // ----------------------------------------------------------------
        div_tick = (q_ff.divcnt == 16'h0000);
        nxt_q.divcnt = div_tick ? q_ff.div : q_ff.divcnt - 16'h0001;
        case (csel)
            TCP_CLK_SYS: begin
                src_tick = 1'b1;
            end
            TCP_CLK_DIV: begin
                src_tick = div_tick;
            end
            TCP_CLK_PIN_RISE: begin
                src_tick = rise[`TCP_PIN_XCLK];
            end
            TCP_CLK_PIN_FALL: begin
                src_tick = fall[`TCP_PIN_XCLK];
            end
            default: begin
                src_tick = 1'b0;
            end
        endcase

        // reserved mode code behaves as free running
        advance = q_ff.ctrl[`TCP_CTRL_RUN] & q_ff.running & src_tick &
                  ((mode != TCP_MODE_ENABLE) | q_ff.filt[`TCP_PIN_EN]);

        start = i_wr & (i_addr == `TCP_OFF_CTRL) & i_wdata[`TCP_CTRL_START];

        // ----------------------------------------------------------------
        // counter
        // ----------------------------------------------------------------
        if (start) begin
            nxt_q.count = q_ff.period;
            nxt_q.running = 1'b1;
        end else if (rise[`TCP_PIN_RST]) begin
            // restart of the period does not revive a stopped one shot
            nxt_q.count = q_ff.period;
        end else if (advance) begin
            if (q_ff.count == 16'h0000) begin
                nxt_q.tc = 1'b1;
                set_ev[`TCP_ST_TC] = 1'b1;
                if (mode == TCP_MODE_ONESHOT) begin
                    nxt_q.running = 1'b0;
                end else begin
                    nxt_q.count = q_ff.period;
                end
            end else begin
                nxt_q.count = q_ff.count - 16'h0001;
            end
        end

        // ----------------------------------------------------------------
        // capture and compare
        // ----------------------------------------------------------------
        if (rise[`TCP_PIN_CAP]) begin
            nxt_q.capture = q_ff.count;
            set_ev[`TCP_ST_CAP] = 1'b1;
        end

        case (rel)
            TCP_REL_LT: begin
                cmp_true = q_ff.count < q_ff.compare;
            end
            TCP_REL_LTE: begin
                cmp_true = q_ff.count <= q_ff.compare;
            end
            TCP_REL_EQ: begin
                cmp_true = q_ff.count == q_ff.compare;
            end
            TCP_REL_GTE: begin
                cmp_true = q_ff.count >= q_ff.compare;
            end
            TCP_REL_GT: begin
                cmp_true = q_ff.count > q_ff.compare;
            end
            default: begin
                cmp_true = 1'b0;
            end
        endcase
        nxt_q.pwm = cmp_true;
        set_ev[`TCP_ST_CMP] = cmp_true & ~q_ff.pwm;

        // ----------------------------------------------------------------
        // register writes
        // ----------------------------------------------------------------
        if (i_wr) begin
            case (i_addr)
                `TCP_OFF_CTRL: begin
                    // start is a command, never stored
                    nxt_q.ctrl = i_wdata[`TCP_CTRL_W-1:0] &
                                 ~(`TCP_CTRL_W'(1) << `TCP_CTRL_START);
                end
                `TCP_OFF_PERIOD: begin
                    nxt_q.period = i_wdata[15:0];
                end
                `TCP_OFF_COMPARE: begin
                    nxt_q.compare = i_wdata[15:0];
                end
                `TCP_OFF_DEADBAND: begin
                    nxt_q.deadband = i_wdata[7:0];
                end
                `TCP_OFF_STATUS: begin
                    clr_ev = i_wdata[2:0];
                end
                `TCP_OFF_DIV: begin
                    nxt_q.div = i_wdata[15:0];
                end
                default: begin
                    clr_ev = 3'h0;
                end
            endcase
        end

        // a new event beats a clear in the same cycle
        nxt_q.sticky = (q_ff.sticky & ~clr_ev) | set_ev;
        nxt_q.irq = |(nxt_q.sticky & nxt_q.ctrl[`TCP_CTRL_IMASK +: 3]);

        // ----------------------------------------------------------------
        // register reads, answered one cycle later
        // ----------------------------------------------------------------
        nxt_q.rdata = 32'h0000_0000;
        if (i_rd) begin
            case (i_addr)
                `TCP_OFF_CTRL: begin
                    nxt_q.rdata = {19'h0_0000, q_ff.ctrl};
                end
                `TCP_OFF_PERIOD: begin
                    nxt_q.rdata = {16'h0000, q_ff.period};
                end
                `TCP_OFF_COMPARE: begin
                    nxt_q.rdata = {16'h0000, q_ff.compare};
                end
                `TCP_OFF_DEADBAND: begin
                    nxt_q.rdata = {24'h00_0000, q_ff.deadband};
                end
                `TCP_OFF_COUNT: begin
                    nxt_q.rdata = {16'h0000, q_ff.count};
                end
                `TCP_OFF_CAPTURE: begin
                    nxt_q.rdata = {16'h0000, q_ff.capture};
                end
                `TCP_OFF_STATUS: begin
                    nxt_q.rdata = {28'h000_0000, q_ff.running, q_ff.sticky};
                end
                `TCP_OFF_DIV: begin
                    nxt_q.rdata = {16'h0000, q_ff.div};
                end
                default: begin
                    nxt_q.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_ff <= '0;
            q_ff.ctrl <= `TCP_CTRL_RST;
            q_ff.period <= `TCP_PERIOD_RST;
            q_ff.compare <= `TCP_COMPARE_RST;
            q_ff.deadband <= `TCP_DEADBAND_RST;
            q_ff.div <= `TCP_DIV_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ----------------------------------------------------------------
    // output stage
    // ----------------------------------------------------------------
    assign dbi.raw = q_ff.pwm;
    assign dbi.tick = advance;
    assign dbi.comp_en = q_ff.ctrl[`TCP_CTRL_COMP];
    assign dbi.kill = q_ff.filt[`TCP_PIN_KILL];
    assign dbi.band = q_ff.deadband;

    tcp_deadband i_tcp_deadband (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .bus(dbi.db)
    );

    assign o_cmp = dbi.out_t;
    assign o_cmp_n = dbi.out_c;
    assign o_tc = q_ff.tc;
    assign o_irq = q_ff.irq;
    assign o_rdata = q_ff.rdata;

endmodule

// [tb/tcp_timer_assertions.sv]
// port assertions of the timer/counter/pwm unit
`timescale 1ns/1ps
`include "tcp_params.svh"
module tcp_timer_assertions (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_kill,
    input wire logic o_cmp,
    input wire logic o_cmp_n,
    input wire logic o_tc,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // --------
    // helpers
    // --------
    logic [15:0] per_ff = 16'h0;
    always_ff @(posedge i_clk) begin
        if (i_wr && i_addr == `TCP_OFF_PERIOD) begin
            per_ff <= i_wdata[15:0];
        end
    end
    sequence s_wr_per;
        i_wr && i_addr == `TCP_OFF_PERIOD;
    endsequence
    sequence s_rd_per;
        i_rd && i_addr == `TCP_OFF_PERIOD;
    endsequence
    // kill passes three filter stages, so allow eight cycles
    sequence s_killed;
        i_kill [*8];
    endsequence

    // --------
    // properties
    // --------
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside its slot");
    a_reset_quiet: assert property ($past(i_rst) |-> !o_tc && !o_irq && !o_cmp && o_rdata == 32'h0)
        else $error("outputs active after reset");
    a_unmapped_zero: assert property (i_rd && i_addr == 8'h20 |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_period_echo: assert property (s_wr_per ##1 s_rd_per |=> o_rdata == {16'h0, per_ff})
        else $error("period readback wrong");
    a_ctrl_high_zero: assert property (i_rd && i_addr == `TCP_OFF_CTRL |=> o_rdata[31:13] == 19'h0)
        else $error("control high bits not zero");
    a_kill_off: assert property (s_killed |-> !o_cmp && !o_cmp_n)
        else $error("outputs on while killed");
    a_no_overlap: assert property (!(o_cmp && o_cmp_n))
        else $error("both pwm outputs on");
    a_tc_pulse: assert property (o_tc |=> !o_tc)
        else $error("terminal count longer than one cycle");
endmodule

// [tb/tcp_pin_model.sv]
// pin-side model driving the timer's routed inputs
`timescale 1ns/1ps
module tcp_pin_model (
    input wire logic i_clk,
    input wire logic [3:0] i_lvl,
    output logic o_ext_clk,
    output logic o_tmr_rst,
    output logic o_capture,
    output logic o_kill,
    output logic o_enable
);
    logic [1:0] ph_ff = 2'h0;
    initial begin
        o_ext_clk = 1'b0;
        {o_kill, o_enable, o_capture, o_tmr_rst} = 4'h0;
    end
    // free count clock of 8 system cycles, slow enough for the input filter
    always @(posedge i_clk) begin
        ph_ff <= ph_ff + 2'h1;
        if (ph_ff == 2'h3) o_ext_clk <= ~o_ext_clk;
        // bench levels reach the pins one cycle later; held long enough for the filter
        {o_kill, o_enable, o_capture, o_tmr_rst} <= i_lvl;
    end
endmodule

// [tb/tcp_timer_tb_top.sv]
// self-checking bench of the timer/counter/pwm unit
`timescale 1ns/1ps
`include "tcp_params.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tcp_timer_tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic ext_clk, tmr_rst, capture, kill, enable, o_cmp, o_cmp_n, o_tc, o_irq;
    int num_errors = 0;
    int total_checks = 0;
    int tc_cnt = 0;
    int tc_gap = 0;
    int tc_last = 0;
    int cyc_no = 0;
    logic rd_d = 1'b0;
    logic [31:0] exp_v;
    logic [31:0] exp_q [$];
    logic [31:0] seed = 32'hdf10e7b6;
    logic [3:0] pin_lvl = 4'h0;

    always #12.5 i_clk = ~i_clk;

    tcp_pin_model i_tcp_pin_model (.i_clk(i_clk), .i_lvl(pin_lvl), .o_ext_clk(ext_clk),
        .o_tmr_rst(tmr_rst), .o_capture(capture), .o_kill(kill), .o_enable(enable));
    tcp_timer i_tcp_timer (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk(ext_clk),
        .i_tmr_rst(tmr_rst), .i_capture(capture), .i_kill(kill), .i_enable(enable),
        .o_cmp(o_cmp), .o_cmp_n(o_cmp_n), .o_tc(o_tc), .o_irq(o_irq));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // --------
    // monitor: read data and terminal count spacing
    // --------
    always @(posedge i_clk) begin
        cyc_no++;
        if (rd_d) begin
            exp_v = exp_q.pop_front();
            `CHK(o_rdata, exp_v)
        end
        rd_d <= i_rd;
        if (o_tc) begin
            tc_cnt++;
            tc_gap = cyc_no - tc_last;
            tc_last = cyc_no;
        end
    end

    // --------
    // bus master
    // --------
    task automatic bus(input logic w, r, input logic [7:0] a, input logic [31:0] d);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 32'h0);
    endtask
    task automatic cyc(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h0, 32'h0);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge i_clk);
        num_errors++;
        results();
    end

    // --------
    // scenarios
    // --------
    initial begin
        logic [31:0] rv [9];
        int t [4];
        int n0;
        logic [15:0] c;
        logic ex;
        // less-than against a stopped zero count is true at once, so cmp is sticky
        rv = '{32'h0, 32'hffff, 32'h8000, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0};
        t = '{1, 2, 8, 8};
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        for (int k = 0; k < 9; k++) rd(8'(k * 4), rv[k]);
        // free run, period 3, each clock source; never-true relation keeps compare quiet
        wr(`TCP_OFF_DIV, 32'h1);
        wr(`TCP_OFF_PERIOD, 32'h3);
        for (int s = 0; s < 4; s++) begin
            wr(`TCP_OFF_CTRL, 32'h229 | 32'(s << 6));
            cyc(120);
            `CHK(tc_gap, 4 * t[s])
        end
        wr(`TCP_OFF_CTRL, 32'h0);
        cyc(4);
        wr(`TCP_OFF_STATUS, 32'h7);
        n0 = tc_cnt;
        wr(`TCP_OFF_CTRL, 32'h22b);
        cyc(40);
        `CHK(tc_cnt - n0, 1)
        rd(`TCP_OFF_STATUS, 32'h1);
        // enable mode with the pin low holds the count
        wr(`TCP_OFF_PERIOD, 32'h1234);
        rd(`TCP_OFF_PERIOD, 32'h1234);
        wr(`TCP_OFF_CTRL, 32'h122d);
        cyc(10);
        rd(`TCP_OFF_COUNT, 32'h1234);
        pin_lvl <= 4'b0010;
        cyc(8);
        rd(`TCP_OFF_CAPTURE, 32'h1234);
        // tc is still sticky from the one shot
        rd(`TCP_OFF_STATUS, 32'hd);
        `CHK(o_irq, 1'b1)
        wr(`TCP_OFF_STATUS, 32'h4);
        cyc(3);
        `CHK(o_irq, 1'b0)
        pin_lvl <= 4'b0100;
        cyc(10);
        pin_lvl <= 4'b0001;
        cyc(8);
        pin_lvl <= 4'b0000;
        cyc(8);
        rd(`TCP_OFF_COUNT, 32'h1234);
        for (int r = 0; r < 5; r++) begin
            for (int j = 0; j < 3; j++) begin
                seed = lfsr(seed);
                c = (j == 0) ? 16'h1234 : seed[15:0];
                wr(`TCP_OFF_COMPARE, {16'h0, c});
                wr(`TCP_OFF_CTRL, 32'h105 | 32'(r << 3));
                cyc(8);
                case (r)
                    0: ex = 16'h1234 < c;
                    1: ex = 16'h1234 <= c;
                    2: ex = 16'h1234 == c;
                    3: ex = 16'h1234 >= c;
                    default: ex = 16'h1234 > c;
                endcase
                `CHK(o_cmp, ex)
                `CHK(o_cmp_n, ~ex)
            end
        end
        wr(`TCP_OFF_COMPARE, 32'h0);
        pin_lvl <= 4'b1000;
        cyc(10);
        `CHK(o_cmp, 1'b0)
        `CHK(o_cmp_n, 1'b0)
        pin_lvl <= 4'b0000;
        cyc(10);
        `CHK(o_cmp, 1'b1)
        // gap of four counter ticks; with the count held no tick comes, both stay off
        wr(`TCP_OFF_DEADBAND, 32'h4);
        wr(`TCP_OFF_COMPARE, 32'hffff);
        cyc(10);
        `CHK(o_cmp, 1'b0)
        `CHK(o_cmp_n, 1'b0)
        pin_lvl <= 4'b0100;
        cyc(16);
        `CHK(o_cmp_n, 1'b1)
        `CHK(o_cmp, 1'b0)
        results();
    end
endmodule

bind tcp_timer tcp_timer_assertions i_tcp_timer_assertions (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_kill(i_kill), .o_cmp(o_cmp), .o_cmp_n(o_cmp_n), .o_tc(o_tc), .o_irq(o_irq));
